// file: cpis_pkg.sv
// Package: register map, bit layout and carriers of the clock/power status
package cpis_pkg;

    // ****************************************************
    // Register offsets
    // ****************************************************
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_EN_SET    = 8'h00;
    localparam logic [7:0]  OFF_EN_CLR    = 8'h04;
    localparam logic [7:0]  OFF_MASK      = 8'h08;
    localparam logic [7:0]  OFF_PENDING   = 8'h0C;
    localparam logic [7:0]  OFF_ACK       = 8'h10;
    localparam logic [7:0]  OFF_STATE     = 8'h14;

    // ****************************************************
    // Bit positions and reset values
    // ****************************************************
    localparam int          BIT_EXTRA     = 31;
    localparam int          BIT_BK_VALID  = 30;
    localparam int          BIT_BK_READY  = 16;
    localparam int          BIT_REF_STOP  = 15;
    localparam int          BIT_SYNC_RDY  = 14;
    localparam int          BIT_LOST_ACC  = 13;
    localparam int          BIT_LOST_FINE = 12;
    localparam int          BIT_LOST_CRS  = 11;
    localparam int          BIT_LOCK_ACC  = 10;
    localparam int          BIT_LOCK_FINE = 9;
    localparam int          BIT_LOCK_CRS  = 8;
    localparam int          BIT_BROWNOUT  = 7;
    localparam int          BIT_SUP_LOW   = 6;
    localparam int          BIT_REG_OK    = 5;
    localparam int          BIT_MAIN_OSC  = 1;
    localparam int          BIT_SLOW_OSC  = 0;
    localparam logic [31:0] IRQ_BITS      = 32'h8001_FFE3;
    localparam logic [31:0] STATE_BITS    = 32'h4001_FFE3;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;

    // ****************************************************
    // Carriers
    // ****************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } cpis_bus_s;

    typedef struct packed {
        logic extra_source_31;
        logic backup_values_valid;
        logic backup_iface_ready;
        logic fll_ref_stopped;
        logic fll_sync_ready;
        logic fll_accurate_lock_lost;
        logic fll_fine_lock_lost;
        logic fll_coarse_lock_lost;
        logic fll_accurate_locked;
        logic fll_fine_locked;
        logic fll_coarse_locked;
        logic brownout_detected;
        logic supply_monitor_low;
        logic regulator_ok;
        logic main_osc_ready;
        logic slow_osc_ready;
    } cpis_src_s;

    // Places each named source at its register bit
    function automatic logic [31:0] src_to_word(input cpis_src_s s);
        logic [31:0] w;
        w                = RST_WORD;
        w[BIT_EXTRA]     = s.extra_source_31;
        w[BIT_BK_VALID]  = s.backup_values_valid;
        w[BIT_BK_READY]  = s.backup_iface_ready;
        w[BIT_REF_STOP]  = s.fll_ref_stopped;
        w[BIT_SYNC_RDY]  = s.fll_sync_ready;
        w[BIT_LOST_ACC]  = s.fll_accurate_lock_lost;
        w[BIT_LOST_FINE] = s.fll_fine_lock_lost;
        w[BIT_LOST_CRS]  = s.fll_coarse_lock_lost;
        w[BIT_LOCK_ACC]  = s.fll_accurate_locked;
        w[BIT_LOCK_FINE] = s.fll_fine_locked;
        w[BIT_LOCK_CRS]  = s.fll_coarse_locked;
        w[BIT_BROWNOUT]  = s.brownout_detected;
        w[BIT_SUP_LOW]   = s.supply_monitor_low;
        w[BIT_REG_OK]    = s.regulator_ok;
        w[BIT_MAIN_OSC]  = s.main_osc_ready;
        w[BIT_SLOW_OSC]  = s.slow_osc_ready;
        return w;
    endfunction

endpackage

// file: cpis_top.sv
// Interrupt mask/pending/ack logic and power and clock state register
`timescale 1ns/100ps
`default_nettype none

module cpis_top
(
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire cpis_pkg::cpis_bus_s bus_req,
    output logic [31:0]              rd_data,
    input  wire cpis_pkg::cpis_src_s src_raw,
    output logic                     irq
);
    import cpis_pkg::*;

    // ****************************************************
    // Source synchronisers
    // ****************************************************
    // Sources come from analog cells and other clocks
    logic [31:0] sync1_ff;
    logic [31:0] sync2_ff;
    logic [31:0] prev_ff;
    logic [31:0] src_word;
    logic [31:0] rise_w;
    logic [31:0] state_w;

    assign src_word = src_to_word(src_raw);
    // Rising level is the event; a stuck level fires only once
    assign rise_w   = sync2_ff & ~prev_ff & IRQ_BITS;
    assign state_w  = sync2_ff & STATE_BITS;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_ff <= RST_WORD;
            sync2_ff <= RST_WORD;
            prev_ff  <= RST_WORD;
        end else begin
            sync1_ff <= src_word;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // ****************************************************
    // Address decode
    // ****************************************************
    logic        wr_en_set;
    logic        wr_en_clr;
    logic        wr_ack;
    logic        rd_mask;
    logic        rd_pending;
    logic        rd_state;

    assign wr_en_set  = bus_req.wr && (bus_req.addr == OFF_EN_SET);
    assign wr_en_clr  = bus_req.wr && (bus_req.addr == OFF_EN_CLR);
    assign wr_ack     = bus_req.wr && (bus_req.addr == OFF_ACK);
    assign rd_mask    = bus_req.rd && (bus_req.addr == OFF_MASK);
    assign rd_pending = bus_req.rd && (bus_req.addr == OFF_PENDING);
    assign rd_state   = bus_req.rd && (bus_req.addr == OFF_STATE);

    // ****************************************************
    // Mask and pending registers
    // ****************************************************
    logic [31:0] mask_ff;
    logic [31:0] nxt_mask;
    logic [31:0] pending_ff;
    logic [31:0] nxt_pending;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] ack_bits;

    assign set_bits    = wr_en_set ? (bus_req.wdata & IRQ_BITS) : RST_WORD;
    assign clr_bits    = wr_en_clr ? bus_req.wdata : RST_WORD;
    assign ack_bits    = wr_ack ? bus_req.wdata : RST_WORD;
    assign nxt_mask    = (mask_ff & ~clr_bits) | set_bits;
    // Fresh event wins over an ack in the same cycle
    assign nxt_pending = (pending_ff & ~ack_bits) | rise_w;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask_ff    <= RST_WORD;
            pending_ff <= RST_WORD;
        end else begin
            mask_ff    <= nxt_mask;
            pending_ff <= nxt_pending;
        end
    end

    assign irq = |(pending_ff & mask_ff);

    // ****************************************************
    // Read path
    // ****************************************************
    // Write-only and unmapped offsets read as zero
    logic [31:0] rd_sel;
    logic [31:0] rd_data_ff;

    assign rd_sel = rd_mask    ? mask_ff :
                    rd_pending ? pending_ff :
                    rd_state   ? state_w :
                    RST_WORD;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_ff <= RST_WORD;
        end else begin
            rd_data_ff <= rd_sel;
        end
    end

    assign rd_data = rd_data_ff;

    // ****************************************************
    // Assertions
    // ****************************************************
    mask_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_en_set |=> ((mask_ff & $past(bus_req.wdata) & IRQ_BITS)
                       == ($past(bus_req.wdata) & IRQ_BITS)))
        else $error("mask bit not set by enable write");

    mask_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_en_clr |=> ((mask_ff & $past(bus_req.wdata)) == RST_WORD))
        else $error("mask bit not cleared by disable write");

    mask_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_mask |=> (rd_data == $past(mask_ff)))
        else $error("mask read returned wrong value");

    pend_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        ((sync2_ff & ~prev_ff & IRQ_BITS) != RST_WORD)
        |=> ((pending_ff & $past(rise_w)) == $past(rise_w)))
        else $error("event did not set pending bit");

    ack_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ack |=> ((pending_ff & $past(bus_req.wdata) & ~$past(rise_w))
                    == RST_WORD))
        else $error("ack did not clear pending bit");

    ack_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ack |=> ((pending_ff & ~$past(bus_req.wdata))
                    == (($past(pending_ff) | $past(rise_w))
                        & ~$past(bus_req.wdata))))
        else $error("ack zero bit disturbed pending");

    state_lat_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##2 (state_w == ($past(src_word, 2) & STATE_BITS)))
        else $error("state word not two cycles behind sources");

    state_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_state |=> (rd_data == ($past(state_w) & STATE_BITS)))
        else $error("state read returned wrong value");

    unmapped_a: assert property (@(posedge sys_clk) disable iff (rst)
        (bus_req.rd && !rd_mask && !rd_pending && !rd_state)
        |=> (rd_data == RST_WORD))
        else $error("unmapped read not zero");

    irq_out_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en_clr && ((mask_ff & ~bus_req.wdata) == RST_WORD))
        |=> !irq)
        else $error("irq stayed high with all sources masked");

    irq_event_c: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(irq));
    ack_drop_c: cover property (@(posedge sys_clk) disable iff (rst)
        irq && wr_ack ##1 !irq);
    race_c: cover property (@(posedge sys_clk) disable iff (rst)
        wr_ack && ((bus_req.wdata & rise_w) != RST_WORD));
    state_rd_c: cover property (@(posedge sys_clk) disable iff (rst)
        rd_state && (state_w != RST_WORD));

endmodule // cpis_top

`default_nettype wire

// file: tb_clock_power_irq_status.sv
// Self-checking testbench for the clock/power status and interrupt block
`timescale 1ns/100ps
`default_nettype none

module tb_clock_power_irq_status;
    import cpis_pkg::*;

    logic        sys_clk;
    logic        rst;
    cpis_bus_s   bus_req;
    logic [31:0] rd_data;
    cpis_src_s   src_raw;
    logic        irq;
    int          n_mismatch;
    int          n_compared;
    logic [31:0] exp_pend;
    logic [31:0] got;
    // Row table: source field, MSB first, against its expected register bit
    int          src_pos [16] = '{31, 30, 16, 15, 14, 13, 12, 11,
                                  10, 9, 8, 7, 6, 5, 1, 0};

    cpis_top dut (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bus_req (bus_req),
        .rd_data (rd_data),
        .src_raw (src_raw),
        .irq     (irq)
    );

    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ****************************************************
    // Bus tasks and comparison
    // ****************************************************
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'h0, rd: 1'h0};
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // Read data is taken in the single cycle after the strobe
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h0};
        #1;
        got = rd_data;
        chk(nm, e, got);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Guard against a hang in the main sequence
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        wrap_up();
    end

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        n_mismatch = 0;
        n_compared = 0;
        exp_pend   = 32'h0;
        rst        = 1'h1;
        bus_req    = '0;
        src_raw    = '0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        rd_chk("mask_rst", OFF_MASK, 32'h0);
        rd_chk("pend_rst", OFF_PENDING, 32'h0);
        rd_chk("state_rst", OFF_STATE, 32'h0);
        // Walking one: each source alone, pending stays sticky
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            src_raw <= cpis_src_s'(16'h8000 >> i);
            repeat (4) @(posedge sys_clk);
            rd_chk("state", OFF_STATE, (32'h1 << src_pos[i]) & STATE_BITS);
            if (src_pos[i] != 30) exp_pend |= 32'h1 << src_pos[i];
            rd_chk("pending", OFF_PENDING, exp_pend);
        end
        @(posedge sys_clk);
        src_raw <= '0;
        repeat (4) @(posedge sys_clk);
        chk("irq_unmasked", 32'h0, {31'h0, irq});
        wr_reg(OFF_MASK, 32'hFFFF_FFFF);
        rd_chk("mask_ro", OFF_MASK, 32'h0);
        wr_reg(OFF_EN_SET, 32'hFFFF_FFFF);
        rd_chk("mask_set", OFF_MASK, 32'h8001_FFE3);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr_reg(OFF_EN_CLR, 32'h0000_0020);
        rd_chk("mask_clr", OFF_MASK, 32'h8001_FFC3);
        wr_reg(OFF_PENDING, 32'h0);
        rd_chk("pend_ro", OFF_PENDING, exp_pend);
        wr_reg(OFF_ACK, 32'h0);
        rd_chk("ack_zero", OFF_PENDING, exp_pend);
        wr_reg(OFF_ACK, 32'h0000_0020);
        exp_pend &= ~32'h0000_0020;
        rd_chk("ack_one", OFF_PENDING, exp_pend);
        wr_reg(OFF_EN_CLR, 32'hFFFF_FFFE);
        #1;
        chk("irq_one_src", 32'h1, {31'h0, irq});
        wr_reg(OFF_ACK, 32'h0000_0001);
        #1;
        chk("irq_acked", 32'h0, {31'h0, irq});
        rd_chk("ack_read", OFF_ACK, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        // Reset in mid-run must drop the mask again
        wr_reg(OFF_EN_SET, 32'hFFFF_FFFF);
        @(posedge sys_clk);
        rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        rd_chk("mask_rst2", OFF_MASK, 32'h0);
        rd_chk("pend_rst2", OFF_PENDING, 32'h0);
        wrap_up();
    end
endmodule // tb_clock_power_irq_status

`default_nettype wire
